// ### include/irqc_arb_if.sv
`timescale 1ns/1ps
interface irqc_arb_if #(parameter int PCW = 12);
  irqc_pkg::irqc_srcmask_t pending;
  logic any;
  irqc_pkg::irqc_srcmask_t grant;
  logic [PCW-1:0] vector;

  modport arb (input pending, output any, output grant, output vector);
  modport ctl (output pending, input any, input grant, input vector);
endinterface

// ### include/irqc_cfg.svh
`ifndef IRQC_CFG_SVH
`define IRQC_CFG_SVH

// Register byte offsets
`define IRQC_OFS_CTRL0 4'h0
`define IRQC_OFS_CTRL1 4'h4
`define IRQC_OFS_PINCFG 4'h8
`define IRQC_OFS_STATUS 4'hc

// Control register 0 fields
`define IRQC_C0_GLOBAL_EN 0
`define IRQC_C0_PIN_EN 1
`define IRQC_C0_T0_EN 2
`define IRQC_C0_T1_EN 3
`define IRQC_C0_PIN_FLAG 4
`define IRQC_C0_T0_FLAG 5
`define IRQC_C0_T1_FLAG 6

// Control register 1 fields
`define IRQC_C1_TB_EN 0
`define IRQC_C1_AD_EN 1
`define IRQC_C1_TB_FLAG 4
`define IRQC_C1_AD_FLAG 5

// Pin configuration fields
`define IRQC_PC_LCD_ON 0
`define IRQC_PC_PORTD0 1

// Status fields
`define IRQC_ST_FULL 4
`define IRQC_ST_PEND 5

// Reset values
`define IRQC_RST_CTRL0 8'h00
`define IRQC_RST_CTRL1 8'h00
`define IRQC_RST_PINCFG 8'h02

// Vectors, in priority order
`define IRQC_VEC_PIN 12'h004
`define IRQC_VEC_T0 12'h008
`define IRQC_VEC_T1 12'h00c
`define IRQC_VEC_TB 12'h010
`define IRQC_VEC_AD 12'h014

// Stack depth
`define IRQC_STACK_DEPTH 8

`endif

// ### include/irqc_pkg.sv
package irqc_pkg;

  typedef enum logic [2:0] {
    IRQC_SRC_PIN = 3'b000,
    IRQC_SRC_T0 = 3'b001,
    IRQC_SRC_T1 = 3'b010,
    IRQC_SRC_TB = 3'b011,
    IRQC_SRC_AD = 3'b100
  } irqc_src_e;

  localparam int unsigned IRQC_NSRC = 5;

  typedef logic [IRQC_NSRC-1:0] irqc_srcmask_t;

endpackage

// ### rtl/irqc_prio.sv
`timescale 1ns/1ps
`include "irqc_cfg.svh"
module irqc_prio #(
  parameter int PCW = 12
) (
  irqc_arb_if.arb arb
);

  function automatic logic [PCW-1:0] vec_of(input int unsigned idx);
    logic [PCW-1:0] v;
    v = PCW'(`IRQC_VEC_AD);
    case (idx)
      0: v = PCW'(`IRQC_VEC_PIN);
      1: v = PCW'(`IRQC_VEC_T0);
      2: v = PCW'(`IRQC_VEC_T1);
      3: v = PCW'(`IRQC_VEC_TB);
      default: v = PCW'(`IRQC_VEC_AD);
    endcase
    return v;
  endfunction

  // Lowest index wins; external pin is index zero
  always_comb
  begin
    arb.grant = '0;
    arb.vector = '0;
    arb.any = |arb.pending;
    for (int i = irqc_pkg::IRQC_NSRC - 1; i >= 0; i--)
    begin
      if (arb.pending[i])
      begin
        arb.grant = '0;
        arb.grant[i] = 1'b1;
        arb.vector = vec_of(i);
      end
    end
  end

endmodule // irqc_prio

// ### rtl/irqc_sync.sv
`timescale 1ns/1ps
module irqc_sync (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic async_in,
  output logic sync_out
);

  logic meta;
  logic next_meta;
  logic next_sync_out;

  always_comb
  begin
    next_meta = async_in;
    next_sync_out = meta;
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta <= next_meta;
      sync_out <= next_sync_out;
    end
  end

endmodule // irqc_sync

// ### rtl/irqc_top.sv
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "irqc_cfg.svh"
module irqc_top #(
  parameter int PCW = 12,
  parameter int DEPTH = `IRQC_STACK_DEPTH
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic timer0_ovf,
  input wire logic timer1_ovf,
  input wire logic timebase_ovf,
  input wire logic conv_done,
  input wire logic irq_pin_in,
  output logic irq_pin_out,
  output logic irq_pin_oe,
  input wire logic phase_two_pulse,
  input wire logic [PCW-1:0] pc_next,
  input wire logic call_push,
  input wire logic ret_pop,
  output logic irq_ack,
  output logic [PCW-1:0] irq_vector,
  output logic [PCW-1:0] pc_restore,
  output logic pc_restore_valid,
  output logic stack_full,
  output logic wake_req
);

  localparam int PW = $clog2(DEPTH + 1);
  localparam int NS = irqc_pkg::IRQC_NSRC;

  irqc_arb_if #(.PCW(PCW)) arb_if ();

  // Control state
  logic global_irq_enable;
  logic next_global_irq_enable;
  irqc_pkg::irqc_srcmask_t irq_en;
  irqc_pkg::irqc_srcmask_t next_irq_en;
  irqc_pkg::irqc_srcmask_t irq_flag;
  irqc_pkg::irqc_srcmask_t next_irq_flag;
  logic lcd_drive_on;
  logic next_lcd_drive_on;
  logic port_d_bit0_output;
  logic next_port_d_bit0_output;

  // Pin and phase tracking
  logic pin_s;
  logic pin_d;
  logic next_pin_d;
  logic pin_armed;
  logic next_pin_armed;
  logic t2_d;
  logic next_t2_d;

  // Stack
  logic [PCW-1:0] stk [DEPTH];
  logic [PW-1:0] sp;
  logic [PW-1:0] next_sp;
  logic push_en;
  logic [PCW-1:0] push_val;

  // Outputs next values
  logic [7:0] next_reg_rdata;
  logic next_irq_pin_out;
  logic next_irq_pin_oe;
  logic next_irq_ack;
  logic [PCW-1:0] next_irq_vector;
  logic [PCW-1:0] next_pc_restore;
  logic next_pc_restore_valid;
  logic next_stack_full;
  logic next_wake_req;

  // Decoded strobes
  logic wr_c0;
  logic wr_c1;
  logic wr_pc;
  logic pin_is_input;
  logic pin_edge;
  logic t2_rise;
  logic full_now;
  logic accept;
  logic pop_ok;
  irqc_pkg::irqc_srcmask_t events;

  irqc_sync u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .async_in(irq_pin_in),
    .sync_out(pin_s)
  );

  irqc_prio #(.PCW(PCW)) u_prio (
    .arb(arb_if.arb)
  );

  // Write decode
  always_comb
  begin
    wr_c0 = 1'b0;
    wr_c1 = 1'b0;
    wr_pc = 1'b0;
    if (reg_wr && reg_addr == `IRQC_OFS_CTRL0)
    begin
      wr_c0 = 1'b1;
    end
    else if (reg_wr && reg_addr == `IRQC_OFS_CTRL1)
    begin
      wr_c1 = 1'b1;
    end
    else if (reg_wr && reg_addr == `IRQC_OFS_PINCFG)
    begin
      wr_pc = 1'b1;
    end
  end

  // Event detection and acceptance
  always_comb
  begin
    pin_is_input = irq_en[irqc_pkg::IRQC_SRC_PIN] & ~lcd_drive_on & port_d_bit0_output;
    pin_edge = pin_armed & pin_is_input & (pin_s ^ pin_d);
    events = '0;
    events[irqc_pkg::IRQC_SRC_PIN] = pin_edge;
    events[irqc_pkg::IRQC_SRC_T0] = timer0_ovf;
    events[irqc_pkg::IRQC_SRC_T1] = timer1_ovf;
    events[irqc_pkg::IRQC_SRC_TB] = timebase_ovf;
    events[irqc_pkg::IRQC_SRC_AD] = conv_done;
    arb_if.pending = irq_flag & irq_en;
    t2_rise = phase_two_pulse & ~t2_d;
    full_now = (sp == PW'(DEPTH));
    // Core stack traffic and control register 0 and 1 writes defer acceptance one pulse
    accept = t2_rise & global_irq_enable & arb_if.any & ~full_now
             & ~call_push & ~ret_pop & ~wr_c0 & ~wr_c1;
    pop_ok = ret_pop & (sp != '0);
    next_pin_d = pin_s;
    next_pin_armed = 1'b1;
    next_t2_d = phase_two_pulse;
  end

  // Control and flag next values
  always_comb
  begin
    next_global_irq_enable = global_irq_enable;
    next_irq_en = irq_en;
    next_irq_flag = irq_flag;
    next_lcd_drive_on = lcd_drive_on;
    next_port_d_bit0_output = port_d_bit0_output;
    if (wr_c0)
    begin
      next_global_irq_enable = reg_wdata[`IRQC_C0_GLOBAL_EN];
      next_irq_en[irqc_pkg::IRQC_SRC_PIN] = reg_wdata[`IRQC_C0_PIN_EN];
      next_irq_en[irqc_pkg::IRQC_SRC_T0] = reg_wdata[`IRQC_C0_T0_EN];
      next_irq_en[irqc_pkg::IRQC_SRC_T1] = reg_wdata[`IRQC_C0_T1_EN];
      next_irq_flag[irqc_pkg::IRQC_SRC_PIN] = reg_wdata[`IRQC_C0_PIN_FLAG];
      next_irq_flag[irqc_pkg::IRQC_SRC_T0] = reg_wdata[`IRQC_C0_T0_FLAG];
      next_irq_flag[irqc_pkg::IRQC_SRC_T1] = reg_wdata[`IRQC_C0_T1_FLAG];
    end
    else if (wr_c1)
    begin
      next_irq_en[irqc_pkg::IRQC_SRC_TB] = reg_wdata[`IRQC_C1_TB_EN];
      next_irq_en[irqc_pkg::IRQC_SRC_AD] = reg_wdata[`IRQC_C1_AD_EN];
      next_irq_flag[irqc_pkg::IRQC_SRC_TB] = reg_wdata[`IRQC_C1_TB_FLAG];
      next_irq_flag[irqc_pkg::IRQC_SRC_AD] = reg_wdata[`IRQC_C1_AD_FLAG];
    end
    else if (wr_pc)
    begin
      next_lcd_drive_on = reg_wdata[`IRQC_PC_LCD_ON];
      next_port_d_bit0_output = reg_wdata[`IRQC_PC_PORTD0];
    end
    if (accept)
    begin
      next_global_irq_enable = 1'b0;
      // Only the winner is cleared, lower sources stay pending
      next_irq_flag = next_irq_flag & ~arb_if.grant;
    end
    // Events win over any clear in the same cycle
    next_irq_flag = next_irq_flag | events;
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      global_irq_enable <= 1'(`IRQC_RST_CTRL0 >> `IRQC_C0_GLOBAL_EN);
      irq_en <= '0;
      irq_flag <= '0;
      lcd_drive_on <= 1'(`IRQC_RST_PINCFG >> `IRQC_PC_LCD_ON);
      port_d_bit0_output <= 1'(`IRQC_RST_PINCFG >> `IRQC_PC_PORTD0);
      pin_d <= 1'b0;
      pin_armed <= 1'b0;
      t2_d <= 1'b0;
    end
    else
    begin
      global_irq_enable <= next_global_irq_enable;
      irq_en <= next_irq_en;
      irq_flag <= next_irq_flag;
      lcd_drive_on <= next_lcd_drive_on;
      port_d_bit0_output <= next_port_d_bit0_output;
      pin_d <= next_pin_d;
      pin_armed <= next_pin_armed;
      t2_d <= next_t2_d;
    end
  end

  // Return-address stack, holds program counter only
  always_comb
  begin
    next_sp = sp;
    push_en = 1'b0;
    push_val = pc_next;
    if (accept)
    begin
      push_en = 1'b1;
    end
    else if (call_push && !full_now)
    begin
      push_en = 1'b1;
    end
    if (push_en)
    begin
      next_sp = sp + PW'(1);
    end
    else if (pop_ok)
    begin
      next_sp = sp - PW'(1);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (push_en)
    begin
      stk[sp[$clog2(DEPTH)-1:0]] <= push_val;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sp <= '0;
    end
    else
    begin
      sp <= next_sp;
    end
  end

  // Registered outputs
  always_comb
  begin
    logic [PW-1:0] top;
    top = sp - PW'(1);
    next_reg_rdata = 8'h00;
    if (reg_rd && reg_addr == `IRQC_OFS_CTRL0)
    begin
      next_reg_rdata[`IRQC_C0_GLOBAL_EN] = global_irq_enable;
      next_reg_rdata[`IRQC_C0_PIN_EN] = irq_en[irqc_pkg::IRQC_SRC_PIN];
      next_reg_rdata[`IRQC_C0_T0_EN] = irq_en[irqc_pkg::IRQC_SRC_T0];
      next_reg_rdata[`IRQC_C0_T1_EN] = irq_en[irqc_pkg::IRQC_SRC_T1];
      next_reg_rdata[`IRQC_C0_PIN_FLAG] = irq_flag[irqc_pkg::IRQC_SRC_PIN];
      next_reg_rdata[`IRQC_C0_T0_FLAG] = irq_flag[irqc_pkg::IRQC_SRC_T0];
      next_reg_rdata[`IRQC_C0_T1_FLAG] = irq_flag[irqc_pkg::IRQC_SRC_T1];
    end
    else if (reg_rd && reg_addr == `IRQC_OFS_CTRL1)
    begin
      next_reg_rdata[`IRQC_C1_TB_EN] = irq_en[irqc_pkg::IRQC_SRC_TB];
      next_reg_rdata[`IRQC_C1_AD_EN] = irq_en[irqc_pkg::IRQC_SRC_AD];
      next_reg_rdata[`IRQC_C1_TB_FLAG] = irq_flag[irqc_pkg::IRQC_SRC_TB];
      next_reg_rdata[`IRQC_C1_AD_FLAG] = irq_flag[irqc_pkg::IRQC_SRC_AD];
    end
    else if (reg_rd && reg_addr == `IRQC_OFS_PINCFG)
    begin
      next_reg_rdata[`IRQC_PC_LCD_ON] = lcd_drive_on;
      next_reg_rdata[`IRQC_PC_PORTD0] = port_d_bit0_output;
    end
    else if (reg_rd && reg_addr == `IRQC_OFS_STATUS)
    begin
      next_reg_rdata[3:0] = 4'(sp);
      next_reg_rdata[`IRQC_ST_FULL] = full_now;
      next_reg_rdata[`IRQC_ST_PEND] = arb_if.any;
    end
    next_irq_pin_oe = ~pin_is_input;
    next_irq_pin_out = port_d_bit0_output;
    next_irq_ack = accept;
    next_irq_vector = accept ? arb_if.vector : irq_vector;
    next_pc_restore = pop_ok ? stk[top[$clog2(DEPTH)-1:0]] : pc_restore;
    next_pc_restore_valid = pop_ok;
    next_stack_full = (next_sp == PW'(DEPTH));
    next_wake_req = |(next_irq_flag & next_irq_en);
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      reg_rdata <= 8'h00;
      irq_pin_oe <= 1'b1;
      irq_pin_out <= 1'b1;
      irq_ack <= 1'b0;
      irq_vector <= '0;
      pc_restore <= '0;
      pc_restore_valid <= 1'b0;
      stack_full <= 1'b0;
      wake_req <= 1'b0;
    end
    else
    begin
      reg_rdata <= next_reg_rdata;
      irq_pin_oe <= next_irq_pin_oe;
      irq_pin_out <= next_irq_pin_out;
      irq_ack <= next_irq_ack;
      irq_vector <= next_irq_vector;
      pc_restore <= next_pc_restore;
      pc_restore_valid <= next_pc_restore_valid;
      stack_full <= next_stack_full;
      wake_req <= next_wake_req;
    end
  end

endmodule // irqc_top

// ### verif/irqc_core_model.sv
`timescale 1ns/1ps
module irqc_core_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic irq_ack,
  input wire logic ret_req,
  output logic phase_two_pulse,
  output logic [11:0] pc_next,
  output logic ret_pop
);
  logic [1:0] cnt;
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt <= 2'h0;
      phase_two_pulse <= 1'b0;
      pc_next <= 12'h100;
      ret_pop <= 1'b0;
    end
    else
    begin
      cnt <= cnt + 2'h1;
      phase_two_pulse <= (cnt == 2'h3);
      ret_pop <= ret_req;
      // Jump away after each accept
      if (irq_ack)
        pc_next <= pc_next + 12'h004;
    end
  end
endmodule // irqc_core_model

// ### verif/irqc_top_sva.sv
`timescale 1ns/1ps
`include "irqc_cfg.svh"
module irqc_top_sva #(
  parameter int PCW = 12
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic phase_two_pulse,
  input wire logic ret_pop,
  input wire logic call_push,
  input logic irq_ack,
  input logic [PCW-1:0] irq_vector,
  input logic pc_restore_valid,
  input logic stack_full
);
  logic blocked;
  logic next_blocked;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Inverse of the global enable: a control write loads it, service sets it
  always_comb next_blocked = (reg_wr && reg_addr == `IRQC_OFS_CTRL0) ? ~reg_wdata[`IRQC_C0_GLOBAL_EN]
                                                                      : (irq_ack | blocked);
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      blocked <= 1'b1;
    else
      blocked <= next_blocked;
  end
  ack_one_cycle_a: assert property (irq_ack |=> !irq_ack) else $error("ack too long");
  ack_on_phase_a: assert property (irq_ack |-> $past(phase_two_pulse) && !$past(phase_two_pulse, 2))
    else $error("ack off phase rise");
  vector_legal_a: assert property (irq_ack |->
    irq_vector inside {12'h004, 12'h008, 12'h00c, 12'h010, 12'h014}) else $error("bad vector");
  ack_not_full_a: assert property (irq_ack |-> !$past(stack_full)) else $error("ack while full");
  vector_hold_a: assert property (!irq_ack |-> $stable(irq_vector)) else $error("vector moved");
  global_block_a: assert property (irq_ack |-> !$past(blocked)) else $error("ack without enable");
  full_cause_a: assert property ($rose(stack_full) |-> irq_ack || $past(call_push))
    else $error("full without push");
  pop_cause_a: assert property (pc_restore_valid |-> $past(ret_pop)) else $error("restore without pop");
  cover property (irq_ack && irq_vector == 12'h004);
  cover property (stack_full);
  cover property (pc_restore_valid);
endmodule // irqc_top_sva
bind irqc_top irqc_top_sva #(.PCW(PCW)) u_sva (.core_clk(core_clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .phase_two_pulse(phase_two_pulse), .ret_pop(ret_pop),
  .call_push(call_push), .irq_ack(irq_ack), .irq_vector(irq_vector), .pc_restore_valid(pc_restore_valid),
  .stack_full(stack_full));

// ### verif/test_vectored_interrupt_controller.sv
`timescale 1ns/1ps
module test_vectored_interrupt_controller;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] evs = 4'h0;
  logic irq_pin_in = 1'b1;
  logic ret_req = 1'b0;
  logic call_push = 1'b0;
  logic [7:0] reg_rdata;
  logic irq_pin_out, irq_pin_oe, phase_two_pulse, ret_pop, irq_ack, pc_restore_valid, stack_full, wake_req;
  logic [11:0] pc_next, irq_vector, pc_restore;
  logic [11:0] pushed [$];
  logic [11:0] vecs [5] = '{12'h004, 12'h008, 12'h00c, 12'h010, 12'h014};
  logic [4:0] pend;
  int err_count = 0;
  int num_checks = 0;
  int i;
  irqc_top uut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer0_ovf(evs[0]), .timer1_ovf(evs[1]),
    .timebase_ovf(evs[2]), .conv_done(evs[3]), .irq_pin_in(irq_pin_in), .irq_pin_out(irq_pin_out),
    .irq_pin_oe(irq_pin_oe), .phase_two_pulse(phase_two_pulse), .pc_next(pc_next), .call_push(call_push),
    .ret_pop(ret_pop), .irq_ack(irq_ack), .irq_vector(irq_vector), .pc_restore(pc_restore),
    .pc_restore_valid(pc_restore_valid), .stack_full(stack_full), .wake_req(wake_req));
  irqc_core_model core (.core_clk(core_clk), .sys_rst(sys_rst), .irq_ack(irq_ack), .ret_req(ret_req),
    .phase_two_pulse(phase_two_pulse), .pc_next(pc_next), .ret_pop(ret_pop));
  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end
  task conclude();
    if (err_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [11:0] s, input logic [11:0] e);
    num_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("BAD %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk({4'h0, reg_rdata}, {4'h0, e});
    @(posedge core_clk);
  endtask
  task ev(input logic [3:0] m);
    evs <= m;
    @(posedge core_clk);
    evs <= 4'h0;
  endtask
  task wait_ack(input logic [11:0] v);
    int n;
    n = 0;
    do
    begin
      @(negedge core_clk);
      n++;
    end
    while (irq_ack !== 1'b1 && n < 60);
    chk(12'(irq_ack), 12'h001);
    chk(irq_vector, v);
    pushed.push_back(pc_next);
    @(posedge core_clk);
  endtask
  task quiet(input int n);
    repeat (n)
    begin
      @(negedge core_clk);
      chk(12'(irq_ack), 12'h000);
    end
    @(posedge core_clk);
  endtask
  task pop();
    int n;
    n = 0;
    ret_req <= 1'b1;
    @(posedge core_clk);
    ret_req <= 1'b0;
    do
    begin
      @(negedge core_clk);
      n++;
    end
    while (pc_restore_valid !== 1'b1 && n < 10);
    chk(pc_restore, pushed.pop_back());
    @(posedge core_clk);
  endtask
  initial
  begin
    #50000;
    err_count++;
    conclude();
  end
  initial
  begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rd(4'h0, 8'h00);
    rd(4'h8, 8'h02);
    rd(4'h2, 8'h00);
    for (i = 0; i < 8; i++)
    begin
      ev(4'h1);
      wr(4'h0, 8'h25);
      wait_ack(12'h008);
    end
    rd(4'hc, 8'h18);
    chk(12'(stack_full), 12'h001);
    ev(4'h1);
    wr(4'h0, 8'h25);
    quiet(24);
    pop();
    wait_ack(12'h008);
    repeat (8) pop();
    call_push <= 1'b1;
    @(posedge core_clk);
    call_push <= 1'b0;
    pushed.push_back(pc_next);
    pop();
    rd(4'hc, 8'h00);
    wr(4'h0, 8'h0e);
    @(posedge core_clk);
    wr(4'h4, 8'h03);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk(12'(irq_pin_oe), 12'h000);
    chk(12'(irq_pin_out), 12'h001);
    @(posedge core_clk);
    irq_pin_in <= 1'b0;
    ev(4'hf);
    repeat (6) @(posedge core_clk);
    rd(4'h0, 8'h7e);
    rd(4'h4, 8'h33);
    chk(12'(wake_req), 12'h001);
    pend = 5'h1f;
    for (i = 0; i < 5; i++)
    begin
      wr(4'h0, {1'b0, pend[2:0], 4'hf});
      wait_ack(vecs[i]);
      pend[i] = 1'b0;
      rd(4'h0, {1'b0, pend[2:0], 4'he});
    end
    rd(4'h4, 8'h03);
    irq_pin_in <= 1'b1;
    repeat (6) @(posedge core_clk);
    rd(4'h0, 8'h1e);
    wr(4'h0, 8'h41);
    quiet(16);
    chk(12'(wake_req), 12'h000);
    rd(4'h0, 8'h41);
    wr(4'h8, 8'h01);
    @(posedge core_clk);
    wr(4'h0, 8'h02);
    irq_pin_in <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk(12'(irq_pin_oe), 12'h001);
    chk(12'(irq_pin_out), 12'h000);
    rd(4'h8, 8'h01);
    rd(4'h0, 8'h02);
    sys_rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rd(4'hc, 8'h00);
    rd(4'h0, 8'h00);
    rd(4'h8, 8'h02);
    conclude();
  end
endmodule // test_vectored_interrupt_controller
